// ===== core/stu_top.v
// Contract
// RULE1: Each input action detects rising, falling or both edges on its line.
// RULE2: Start, stop, timer reset and indication actions are each independently enabled and configured.
// RULE3: Every input and output action selects the one trigger line it uses.
// RULE4: A start trigger begins recording at the next frame boundary.
// RULE5: A stop trigger ends recording when the current frame completes.
// RULE6: A timer reset trigger clears the outgoing timer to zero.
// RULE7: An indication trigger captures a timestamp for the host to read.
// RULE8: Each input action ignores a configured number of first matching triggers.
// RULE9: Each input action ignores a configured number of triggers between acted ones.
// RULE10: Software sharing one line for start and stop sets stop skips to one.
// RULE11: An enabled start output event pulses its line when recording starts.
// RULE12: An enabled stop output event pulses its line when recording stops.
// RULE13: Frame measurement event pulses at every frame transition while measuring.
// RULE14: Frame recording event pulses at every frame transition while recording.
// RULE15: Output lines rest low after reset until an action drives them.
// RULE16: Pulse polarity is selectable: positive rises from low, negative falls from high.
// RULE17: Pulse width is programmable in milliseconds up to 99.
// RULE18: A width of zero leaves the line at its active level forever.
// RULE19: Software holds a line high using operational entry, positive, infinite width.
// RULE20: Each output action suppresses a configured number of first pulses.
// RULE21: Each output action suppresses a configured number of pulses between delivered ones.
// RULE22: Software keeps pulse width no longer than one frame period.
// RULE23: There are two trigger input lines and two trigger output lines.
// RULE24: Trigger once acts only on the first qualifying event until re-armed.
// RULE25: Inputs are synchronised and compared with their previous sample for edges.
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "stu_consts.vh"

module stu_skip (
  input wire aclk,
  input wire aresetn,
  input wire arm,
  input wire en,
  input wire once,
  input wire ev,
  input wire [7:0] skip_first,
  input wire [7:0] skip_factor,
  output wire fire
);
  reg [7:0] cnt_q;
  reg started_q;
  reg done_q;
  wire go;

  // A once-armed action goes deaf after its first delivery until re-armed by a write.
  assign go = en & ev & ~(once & done_q); // RULE24
  assign fire = go & (started_q ? (cnt_q >= skip_factor) : (cnt_q >= skip_first)); // RULE8 RULE9 RULE20 RULE21

  // The counter restarts after every delivery so the interval skip repeats.
  always @(posedge aclk) begin
    if (!aresetn || arm) begin
      cnt_q <= 8'h00;
      started_q <= 1'b0;
      done_q <= 1'b0;
    end else if (fire) begin
      cnt_q <= 8'h00;
      started_q <= 1'b1;
      done_q <= 1'b1;
    end else if (go) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // stu_skip

module stu_top #(
  parameter MS_CYCLES = `STU_MS_NS / `STU_CLK_NS
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [1:0] trig_in,
  input wire frame_tick,
  input wire operational_entry_event,
  output reg [1:0] trig_out,
  output reg recording
);
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg aw_have_q;
  reg w_have_q;
  reg [31:0] ctrl_q;
  reg [31:0] in_cfg_q [0:`STU_N_IN-1];
  reg [31:0] out_cfg_q [0:`STU_N_OUT-1];
  reg [1:0] sync1_q;
  reg [1:0] sync2_q;
  reg [1:0] prev_q;
  reg start_pend_q;
  reg stop_pend_q;
  reg [31:0] ms_cnt_q;
  reg [31:0] timer_q;
  reg [31:0] ts_q [0:1];
  reg [1:0] ts_valid_q;
  reg [6:0] width_cnt_q [0:1];
  reg [1:0] busy_q;
  reg [1:0] idle_q;
  reg [31:0] rd_d;
  reg rd_ok;
  wire wr_go;
  wire [31:0] wmask;
  wire [1:0] rise;
  wire [1:0] fall;
  wire [`STU_N_IN-1:0] in_fire;
  wire [`STU_N_OUT-1:0] out_ev;
  wire [`STU_N_OUT-1:0] out_fire;
  wire ms_tick;
  wire rec_start;
  wire rec_stop;
  wire host_start;
  wire host_stop;
  integer k, rk;

  assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // Write address and data are latched independently, in either order.
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= `STU_ZERO32;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `STU_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid & ~wr_go;
      s_axi_wready <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid & ~wr_go;
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q <= `STU_A_TS2 || (awaddr_q >= `STU_A_IN0 &&
          awaddr_q < `STU_A_IN0 + 4 * `STU_N_IN) || (awaddr_q >= `STU_A_OUT0 &&
          awaddr_q < `STU_A_OUT0 + 4 * `STU_N_OUT)) && awaddr_q[1:0] == 2'b00 ? `STU_RESP_OKAY : `STU_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Host start and stop are one-cycle strobes decoded straight from the control write.
  assign host_start = wr_go & (awaddr_q == `STU_A_CTRL) & wstrb_q[0] & wdata_q[`STU_C_HSTART];
  assign host_stop = wr_go & (awaddr_q == `STU_A_CTRL) & wstrb_q[0] & wdata_q[`STU_C_HSTOP];

  // Configuration storage; writing an action's word also re-arms its skip counter.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `STU_ZERO32;
      for (k = 0; k < `STU_N_IN; k = k + 1) in_cfg_q[k] <= `STU_ZERO32;
      for (k = 0; k < `STU_N_OUT; k = k + 1) out_cfg_q[k] <= `STU_ZERO32;
    end else if (wr_go) begin
      if (awaddr_q == `STU_A_CTRL) ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask & 32'h0000_0001);
      for (k = 0; k < `STU_N_IN; k = k + 1)
        if (awaddr_q == `STU_A_IN0 + 4 * k) in_cfg_q[k] <= (in_cfg_q[k] & ~wmask) | (wdata_q & wmask);
      for (k = 0; k < `STU_N_OUT; k = k + 1)
        if (awaddr_q == `STU_A_OUT0 + 4 * k) out_cfg_q[k] <= (out_cfg_q[k] & ~wmask) | (wdata_q & wmask);
    end
  end

  // Read mux; unmapped or misaligned addresses answer SLVERR with zero data.
  always @* begin
    rd_d = `STU_ZERO32;
    rd_ok = (s_axi_araddr[1:0] == 2'b00);
    case (s_axi_araddr)
      `STU_A_CTRL: rd_d = ctrl_q;
      `STU_A_STAT: rd_d = {29'h0000_0000, ts_valid_q, recording};
      `STU_A_TIMER: rd_d = timer_q;
      `STU_A_TS1: rd_d = ts_q[0];
      `STU_A_TS2: rd_d = ts_q[1];
      default: begin
        rd_ok = 1'b0;
        for (rk = 0; rk < `STU_N_IN; rk = rk + 1)
          if (s_axi_araddr == `STU_A_IN0 + 4 * rk) begin
            rd_d = in_cfg_q[rk];
            rd_ok = 1'b1;
          end
        for (rk = 0; rk < `STU_N_OUT; rk = rk + 1)
          if (s_axi_araddr == `STU_A_OUT0 + 4 * rk) begin
            rd_d = out_cfg_q[rk];
            rd_ok = 1'b1;
          end
      end
    endcase
  end

  // One read in flight; arready drops while the data waits for rready.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `STU_ZERO32;
      s_axi_rresp <= `STU_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_d;
      s_axi_rresp <= rd_ok ? `STU_RESP_OKAY : `STU_RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Two-stage synchroniser, then a third stage as the previous sample for edge detection.
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 2'b00;
      sync2_q <= 2'b00;
      prev_q <= 2'b00;
    end else begin
      sync1_q <= trig_in; // RULE23
      sync2_q <= sync1_q;
      prev_q <= sync2_q; // RULE25
    end
  end
  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;

  // Input actions: line and edge select feed a skip counter each.
  genvar gi;
  generate
    for (gi = 0; gi < `STU_N_IN; gi = gi + 1) begin : g_in
      wire ln = in_cfg_q[gi][`STU_F_LINE]; // RULE3
      wire [1:0] pol = in_cfg_q[gi][`STU_F_POL];
      wire ev = (pol == `STU_POL_RISE) ? rise[ln] : (pol == `STU_POL_FALL) ? fall[ln] : (rise[ln] | fall[ln]); // RULE1
      stu_skip u_skip (
        .aclk(aclk),
        .aresetn(aresetn),
        .arm(wr_go && awaddr_q == `STU_A_IN0 + 4 * gi),
        .en(in_cfg_q[gi][`STU_F_EN]), // RULE2
        .once(in_cfg_q[gi][`STU_F_ONCE]),
        .ev(ev),
        .skip_first(in_cfg_q[gi][`STU_F_FIRST]),
        .skip_factor(in_cfg_q[gi][`STU_F_FACTOR]),
        .fire(in_fire[gi])
      );
    end
  endgenerate

  // Recording changes only on a frame boundary, so a whole frame is always kept or dropped.
  assign rec_start = frame_tick & start_pend_q & ~recording; // RULE4
  assign rec_stop = frame_tick & stop_pend_q & recording; // RULE5
  always @(posedge aclk) begin
    if (!aresetn) begin
      start_pend_q <= 1'b0;
      stop_pend_q <= 1'b0;
      recording <= 1'b0;
    end else begin
      if (in_fire[`STU_IA_START] || host_start) start_pend_q <= 1'b1;
      else if (frame_tick) start_pend_q <= 1'b0;
      if (in_fire[`STU_IA_STOP] || host_stop) stop_pend_q <= 1'b1;
      else if (frame_tick) stop_pend_q <= 1'b0;
      if (rec_start) recording <= 1'b1;
      else if (rec_stop) recording <= 1'b0;
    end
  end

  // Millisecond timebase for the outgoing timer and pulse widths.
  assign ms_tick = (ms_cnt_q == MS_CYCLES - 1);
  always @(posedge aclk) begin
    if (!aresetn) begin
      ms_cnt_q <= `STU_ZERO32;
      timer_q <= `STU_ZERO32;
    end else begin
      ms_cnt_q <= ms_tick ? `STU_ZERO32 : ms_cnt_q + 32'h0000_0001;
      if (in_fire[`STU_IA_TRST]) begin
        timer_q <= `STU_ZERO32; // RULE6
        ms_cnt_q <= `STU_ZERO32;
      end else if (ms_tick) begin
        timer_q <= timer_q + 32'h0000_0001;
      end
    end
  end

  // Timestamp per line; a new capture wins over a same-cycle write-one clear.
  always @(posedge aclk) begin
    if (!aresetn) begin
      ts_q[0] <= `STU_ZERO32;
      ts_q[1] <= `STU_ZERO32;
      ts_valid_q <= 2'b00;
    end else begin
      if (wr_go && awaddr_q == `STU_A_STAT && wstrb_q[0])
        ts_valid_q <= ts_valid_q & ~wdata_q[`STU_S_TS2:`STU_S_TS1];
      if (in_fire[`STU_IA_IND]) begin
        ts_q[in_cfg_q[`STU_IA_IND][`STU_F_LINE]] <= timer_q; // RULE7
        ts_valid_q[in_cfg_q[`STU_IA_IND][`STU_F_LINE]] <= 1'b1;
      end
    end
  end

  // Output event sources.
  assign out_ev[`STU_OA_START] = rec_start; // RULE11
  assign out_ev[`STU_OA_STOP] = rec_stop; // RULE12
  assign out_ev[`STU_OA_OPER] = operational_entry_event;
  assign out_ev[`STU_OA_FMEAS] = frame_tick & ctrl_q[`STU_C_MEAS]; // RULE13
  assign out_ev[`STU_OA_FREC] = frame_tick & (recording | rec_start); // RULE14

  generate
    for (gi = 0; gi < `STU_N_OUT; gi = gi + 1) begin : g_out
      stu_skip u_skip (
        .aclk(aclk),
        .aresetn(aresetn),
        .arm(wr_go && awaddr_q == `STU_A_OUT0 + 4 * gi),
        .en(out_cfg_q[gi][`STU_F_EN]),
        .once(out_cfg_q[gi][`STU_F_ONCE]),
        .ev(out_ev[gi]),
        .skip_first(out_cfg_q[gi][`STU_F_FIRST]),
        .skip_factor(out_cfg_q[gi][`STU_F_FACTOR]),
        .fire(out_fire[gi])
      );
    end

    // Pulse generator per line; the lowest-numbered firing action wins a collision.
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_line
      reg hit;
      reg neg;
      reg [6:0] wid;
      integer j;
      always @* begin
        hit = 1'b0;
        neg = 1'b0;
        wid = 7'h00;
        for (j = `STU_N_OUT - 1; j >= 0; j = j - 1)
          if (out_fire[j] && out_cfg_q[j][`STU_F_LINE] == gi) begin // RULE3
            hit = 1'b1;
            neg = out_cfg_q[j][`STU_F_NEG];
            wid = (out_cfg_q[j][`STU_F_WIDTH] > `STU_MAX_WIDTH_MS) ? `STU_MAX_WIDTH_MS : out_cfg_q[j][`STU_F_WIDTH]; // RULE17
          end
      end
      // Width counts whole ms ticks, so the first step may be up to one ms short.
      always @(posedge aclk) begin
        if (!aresetn) begin
          trig_out[gi] <= 1'b0; // RULE15
          idle_q[gi] <= 1'b0;
          busy_q[gi] <= 1'b0;
          width_cnt_q[gi] <= 7'h00;
        end else if (hit) begin
          trig_out[gi] <= ~neg; // RULE16
          idle_q[gi] <= neg;
          busy_q[gi] <= (wid != 7'h00); // RULE18
          width_cnt_q[gi] <= wid;
        end else if (busy_q[gi] && ms_tick) begin
          if (width_cnt_q[gi] == 7'h01) begin
            trig_out[gi] <= idle_q[gi];
            busy_q[gi] <= 1'b0;
          end
          width_cnt_q[gi] <= width_cnt_q[gi] - 7'h01;
        end
      end
    end
  endgenerate
endmodule // stu_top

// ===== core/stu_consts.vh
`ifndef STU_CONSTS_VH
`define STU_CONSTS_VH
// Clock period and millisecond length in ns; the pulse timebase derives from both.
`define STU_CLK_NS 10
`define STU_MS_NS 1000000
`define STU_MAX_WIDTH_MS 7'd99
// Register byte addresses.
`define STU_A_CTRL 8'h00
`define STU_A_STAT 8'h04
`define STU_A_TIMER 8'h08
`define STU_A_TS1 8'h0C
`define STU_A_TS2 8'h10
`define STU_A_IN0 8'h20
`define STU_A_OUT0 8'h40
`define STU_N_IN 4
`define STU_N_OUT 5
// Input action indices.
`define STU_IA_START 0
`define STU_IA_STOP 1
`define STU_IA_TRST 2
`define STU_IA_IND 3
// Output action indices.
`define STU_OA_START 0
`define STU_OA_STOP 1
`define STU_OA_OPER 2
`define STU_OA_FMEAS 3
`define STU_OA_FREC 4
// Configuration fields of input and output actions; POL is input only, NEG and WIDTH are output only.
`define STU_F_EN 0
`define STU_F_LINE 1
`define STU_F_ONCE 4
`define STU_F_POL 3:2
`define STU_F_FIRST 15:8
`define STU_F_FACTOR 23:16
`define STU_F_WIDTH 30:24
`define STU_F_NEG 2
// Edge sensitivity codes.
`define STU_POL_RISE 2'd0
`define STU_POL_FALL 2'd1
// Control and status bits.
`define STU_C_MEAS 0
`define STU_C_HSTART 1
`define STU_C_HSTOP 2
`define STU_S_REC 0
`define STU_S_TS1 1
`define STU_S_TS2 2
`define STU_RESP_OKAY 2'b00
`define STU_RESP_SLVERR 2'b10
`define STU_ZERO32 32'h0000_0000
`endif

// ===== bench/stu_checker.sv
`timescale 1ns/100ps
module stu_checker (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire frame_tick,
  input wire [1:0] trig_out,
  input wire recording
);
  // Every check lives in the single clock domain and is quiet during reset.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A pending answer, and its completion, are the steps of each response check.
  sequence s_b_wait; s_axi_bvalid && !s_axi_bready; endsequence
  sequence s_r_wait; s_axi_rvalid && !s_axi_rready; endsequence
  sequence s_r_done; s_axi_rvalid && s_axi_rready; endsequence
  property p_out_idle; $rose(aresetn) |-> trig_out == 2'b00; endproperty
  a_out_idle: assert property (p_out_idle) else $error("output lines not low after reset");
  property p_rec_start; $rose(recording) |-> $past(frame_tick); endproperty
  a_rec_start: assert property (p_rec_start) else $error("recording began off a frame boundary");
  property p_rec_stop; $fell(recording) |-> $past(frame_tick); endproperty
  a_rec_stop: assert property (p_rec_stop) else $error("recording ended inside a frame");
  property p_b_hold; s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_b_close; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_close: assert property (p_b_close) else $error("write response repeated");
  property p_wr_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wr_block: assert property (p_wr_block) else $error("write taken while response pending");
  property p_r_hold; s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data changed before taken");
  property p_r_close; s_r_done |=> !s_axi_rvalid ##1 s_axi_arready; endproperty
  a_r_close: assert property (p_r_close) else $error("read channel not reopened in time");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read address taken while data pending");
endmodule // stu_checker

// ===== bench/stu_instr.sv
`timescale 1ns/100ps
module stu_instr (
  input wire aclk,
  input wire [1:0] trig_out,
  output reg [1:0] trig_in
);
  reg [1:0] prev_q = 2'b00;
  integer cnt1_q = 0;
  integer cnt2_q = 0;
  initial trig_in = 2'b00;
  // Levels change only after an edge and then stay put, so each edge is seen once.
  task drive(input integer line, input reg v);
    begin
      @(posedge aclk);
      trig_in[line] <= v;
    end
  endtask
  // Count rising edges of each output line, as a pulse-counting instrument would.
  always @(posedge aclk) begin
    prev_q <= trig_out;
    if (trig_out[0] === 1'b1 && prev_q[0] === 1'b0) cnt1_q <= cnt1_q + 1;
    if (trig_out[1] === 1'b1 && prev_q[1] === 1'b0) cnt2_q <= cnt2_q + 1;
  end
endmodule // stu_instr

// ===== bench/sync_trigger_io_unit_tb.sv
`timescale 1ns/100ps
`include "stu_consts.vh"
module sync_trigger_io_unit_tb;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] awaddr = 8'h00;
  reg [7:0] araddr = 8'h00;
  reg [31:0] wdata = 32'h0000_0000;
  reg awvalid = 1'b0;
  reg wvalid = 1'b0;
  reg bready = 1'b0;
  reg arvalid = 1'b0;
  reg rready = 1'b0;
  reg frame_tick = 1'b0;
  reg oper_ev = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, recording;
  wire [1:0] bresp, rresp, trig_in, trig_out;
  wire [31:0] rdata;
  reg [31:0] rd_q;
  reg [1:0] resp_q;
  integer fail_count = 0;
  integer samples_checked = 0;
  integer cyc = 0;
  integer base_q;
  integer n;
  always #5 aclk = ~aclk;
  stu_top #(.MS_CYCLES(10)) u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .trig_in(trig_in), .frame_tick(frame_tick), .operational_entry_event(oper_ev),
    .trig_out(trig_out), .recording(recording));
  stu_instr u_inst (.aclk(aclk), .trig_out(trig_out), .trig_in(trig_in));
  task chk(input string what, input [31:0] e, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        $display("wrong value %s expected %h seen %h", what, e, g);
        fail_count = fail_count + 1;
      end
    end
  endtask
  // Address and data go out together; each is dropped as soon as it is taken.
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge aclk);
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp_q = bresp;
      bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd_q = rdata;
      resp_q = rresp;
      rready <= 1'b0;
    end
  endtask
  task tick;
    begin
      @(posedge aclk); frame_tick <= 1'b1;
      @(posedge aclk); frame_tick <= 1'b0;
      repeat (2) @(posedge aclk);
    end
  endtask
  task wrap_up;
    begin
      if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  // A hung handshake ends the run as a failure instead of stalling it.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      wrap_up;
    end
  end
  // Main sequence: after the reset and address-hole checks, each step configures through the bus, then stimulates its inputs.
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("trig_out", 32'h0, {30'h0, trig_out});
    rd(`STU_A_OUT0); chk("out0 cfg", 32'h0, rd_q);
    rd(8'h14); chk("hole rdata", 32'h0, rd_q); chk("hole rresp", 32'h2, {30'h0, resp_q});
    wr(8'h14, 32'h0000_0001); chk("hole bresp", 32'h2, {30'h0, resp_q});
    wr(`STU_A_IN0, 32'h0000_0101);
    wr(`STU_A_OUT0, 32'h0300_0003);
    u_inst.drive(0, 1'b1); repeat (6) @(posedge aclk); tick;
    chk("rec skip", 32'h0, {31'h0, recording});
    u_inst.drive(0, 1'b0); u_inst.drive(0, 1'b1); repeat (6) @(posedge aclk);
    chk("rec early", 32'h0, {31'h0, recording});
    tick;
    chk("rec on", 32'h1, {31'h0, recording});
    chk("start pulse", 32'h1, {31'h0, trig_out[1]});
    repeat (40) @(posedge aclk);
    chk("pulse end", 32'h0, {31'h0, trig_out[1]});
    rd(`STU_A_STAT); chk("stat rec", 32'h1, rd_q);
    wr(`STU_A_OUT0 + 8'h0c, 32'h0201_0103);
    wr(`STU_A_OUT0 + 8'h10, 32'h0200_0001);
    wr(`STU_A_CTRL, 32'h0000_0001);
    base_q = u_inst.cnt2_q;
    repeat (5) begin
      tick; repeat (36) @(posedge aclk);
    end
    chk("meas pulses", 32'd2, u_inst.cnt2_q - base_q);
    chk("frame pulses", 32'd5, u_inst.cnt1_q);
    wr(`STU_A_OUT0 + 8'h0c, 32'h0); wr(`STU_A_OUT0 + 8'h10, 32'h0);
    wr(`STU_A_IN0 + 8'h04, 32'h0000_0005);
    wr(`STU_A_OUT0 + 8'h04, 32'h0200_0007);
    u_inst.drive(0, 1'b0); repeat (6) @(posedge aclk);
    chk("rec held", 32'h1, {31'h0, recording});
    tick;
    chk("rec off", 32'h0, {31'h0, recording});
    chk("neg pulse", 32'h0, {31'h0, trig_out[1]});
    repeat (30) @(posedge aclk);
    chk("neg idle", 32'h1, {31'h0, trig_out[1]});
    wr(`STU_A_OUT0 + 8'h08, 32'h0000_0001);
    @(posedge aclk); oper_ev <= 1'b1;
    @(posedge aclk); oper_ev <= 1'b0;
    repeat (200) @(posedge aclk);
    chk("held line", 32'h1, {31'h0, trig_out[0]});
    wr(`STU_A_IN0, 32'h0);
    wr(`STU_A_IN0 + 8'h08, 32'h0000_000b);
    wr(`STU_A_IN0 + 8'h0c, 32'h0000_0001);
    u_inst.drive(1, 1'b1); repeat (44) @(posedge aclk);
    u_inst.drive(0, 1'b1); repeat (6) @(posedge aclk);
    rd(`STU_A_TS1); chk("stamp", 32'd4, rd_q);
    rd(`STU_A_STAT); chk("stamp flag", 32'h2, rd_q);
    // Start and stop share line 2, start on rising and stop on falling edges, with skip settings that make them alternate.
    wr(`STU_A_IN0, 32'h0001_0003); wr(`STU_A_IN0 + 8'h04, 32'h0001_0107);
    for (n = 0; n < 3; n = n + 1) begin
      u_inst.drive(1, 1'b0); u_inst.drive(1, 1'b1); repeat (6) @(posedge aclk); tick;
      chk("shared line rec", {31'h0, ~n[0]}, {31'h0, recording});
    end
    // A once-armed frame pulse must answer the first frame only, not the second.
    repeat (40) @(posedge aclk);
    wr(`STU_A_OUT0 + 8'h0c, 32'h0100_0013);
    base_q = u_inst.cnt2_q;
    repeat (2) begin
      tick; repeat (26) @(posedge aclk);
    end
    chk("once pulses", 32'd1, u_inst.cnt2_q - base_q);
    wrap_up;
  end
endmodule // sync_trigger_io_unit_tb
bind stu_top stu_checker u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .frame_tick(frame_tick),
  .trig_out(trig_out), .recording(recording));
